// ### rtl/pattern_gen_color_bytes_defs.vh
// register offsets, reset values and sizes of the pattern generator color byte table
`ifndef PATTERN_GEN_COLOR_BYTES_DEFS_VH
`define PATTERN_GEN_COLOR_BYTES_DEFS_VH

// ************************************************
// register offsets
// ************************************************
`define COLOR_BYTE_ZERO_OFS   8'h10
`define COLOR_BYTE_ONE_OFS    8'h11
`define COLOR_BYTE_TWO_OFS    8'h12
`define COLOR_BYTE_THREE_OFS  8'h13
`define COLOR_BYTE_FOUR_OFS   8'h14
`define COLOR_BYTE_FIVE_OFS   8'h15
`define COLOR_BYTE_SIX_OFS    8'h16
`define COLOR_BYTE_SEVEN_OFS  8'h17
`define COLOR_BYTE_EIGHT_OFS  8'h18
`define COLOR_BYTE_NINE_OFS   8'h19
`define COLOR_BYTE_TEN_OFS    8'h1a
`define COLOR_BYTE_ELEVEN_OFS 8'h1b
`define COLOR_BYTE_TWELVE_OFS 8'h1c
`define COLOR_BYTE_THIRTEEN_OFS 8'h1d
`define COLOR_BYTE_FOURTEEN_OFS 8'h1e

// ************************************************
// reset values
// ************************************************
`define COLOR_BYTE_ZERO_RST   8'haa
`define COLOR_BYTE_ONE_RST    8'h33
`define COLOR_BYTE_TWO_RST    8'hf0
`define COLOR_BYTE_THREE_RST  8'h7f
`define COLOR_BYTE_FOUR_RST   8'h55
`define COLOR_BYTE_FIVE_RST   8'hcc
`define COLOR_BYTE_SIX_RST    8'h0f
`define COLOR_BYTE_SEVEN_RST  8'h80
`define COLOR_BYTE_UPPER_RST  8'h00

// ************************************************
// table shape and modes
// ************************************************
`define COLOR_BYTE_COUNT      15
`define COLOR_BAR_COUNT       8
`define COLOR_LAST_INDEX      4'he
`define MODE_COLOR_BAR        1'b0
`define MODE_FIXED_COLOR      1'b1
`define READ_UNMAPPED         8'h00

`endif

// ### rtl/pattern_gen_color_bytes.v
// color byte table of the test pattern generator with register port and byte output
//
// Functional notes
// - in color bar mode bar 4 emits the byte at offset 0x14, which resets to 0x55.
// - in color bar mode bar 5 emits the byte at offset 0x15, which resets to 0xcc.
// - in color bar mode bar 6 emits the byte at offset 0x16, which resets to 0x0f.
// - in color bar mode bar 7 emits the byte at offset 0x17, which resets to 0x80.
// - in fixed color mode sequence bytes five to eight come from offsets 0x14 to 0x17 in order.
// - in fixed color mode sequence bytes nine to twelve come from offsets 0x18 to 0x1b, resetting to 0x00.
// - offsets 0x10 to 0x13 give bars 0 to 3 and the first four fixed color bytes.
// - offsets 0x1c to 0x1e give fixed color bytes thirteen to fifteen and serve fixed mode only.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "pattern_gen_color_bytes_defs.vh"

module pattern_gen_color_bytes #(
    parameter BYTE_W = 8
) (
    // clock and reset
    input wire ref_clk,
    input wire resetn,
    // register port
    input wire [7:0] reg_addr,
    input wire [BYTE_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [BYTE_W-1:0] reg_rdata,
    // pattern side
    input wire gen_mode,
    input wire gen_restart,
    input wire gen_req,
    input wire [2:0] gen_bar,
    output reg [BYTE_W-1:0] gen_byte,
    output reg gen_valid,
    output reg [3:0] gen_pos
);

    // ************************************************
    // reset synchroniser
    // ************************************************
    reg rst_meta_reg;
    reg rst_sync_reg;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    wire rst_n = rst_sync_reg;

    // ************************************************
    // table constants
    // ************************************************
    localparam ENTRIES = `COLOR_BYTE_COUNT;
    localparam [3:0] FIRST_POS = 4'h0;
    // position 15 is never reached; the sequence wraps after the last entry
    localparam [3:0] LAST_POS = `COLOR_LAST_INDEX;
    localparam [BYTE_W-1:0] UNMAPPED_BYTE = `READ_UNMAPPED;

    // ************************************************
    // decode helpers
    // ************************************************
    // offset to table slot: bit 4 marks a hit, bits 3:0 name the entry
    function [4:0] slot_of;
        input [7:0] addr;
        begin
            case (addr)
                `COLOR_BYTE_ZERO_OFS: begin
                    slot_of = 5'h10;
                end
                `COLOR_BYTE_ONE_OFS: begin
                    slot_of = 5'h11;
                end
                `COLOR_BYTE_TWO_OFS: begin
                    slot_of = 5'h12;
                end
                `COLOR_BYTE_THREE_OFS: begin
                    slot_of = 5'h13;
                end
                `COLOR_BYTE_FOUR_OFS: begin
                    slot_of = 5'h14;
                end
                `COLOR_BYTE_FIVE_OFS: begin
                    slot_of = 5'h15;
                end
                `COLOR_BYTE_SIX_OFS: begin
                    slot_of = 5'h16;
                end
                `COLOR_BYTE_SEVEN_OFS: begin
                    slot_of = 5'h17;
                end
                `COLOR_BYTE_EIGHT_OFS: begin
                    slot_of = 5'h18;
                end
                `COLOR_BYTE_NINE_OFS: begin
                    slot_of = 5'h19;
                end
                `COLOR_BYTE_TEN_OFS: begin
                    slot_of = 5'h1a;
                end
                `COLOR_BYTE_ELEVEN_OFS: begin
                    slot_of = 5'h1b;
                end
                `COLOR_BYTE_TWELVE_OFS: begin
                    slot_of = 5'h1c;
                end
                `COLOR_BYTE_THIRTEEN_OFS: begin
                    slot_of = 5'h1d;
                end
                `COLOR_BYTE_FOURTEEN_OFS: begin
                    slot_of = 5'h1e;
                end
                default: begin
                    slot_of = 5'h00;
                end
            endcase
        end
    endfunction

    // reset value of each entry; entries past bar 7 clear to zero
    function [7:0] reset_value;
        input integer idx;
        begin
            case (idx)
                0: begin
                    reset_value = `COLOR_BYTE_ZERO_RST;
                end
                1: begin
                    reset_value = `COLOR_BYTE_ONE_RST;
                end
                2: begin
                    reset_value = `COLOR_BYTE_TWO_RST;
                end
                3: begin
                    reset_value = `COLOR_BYTE_THREE_RST;
                end
                4: begin
                    reset_value = `COLOR_BYTE_FOUR_RST;
                end
                5: begin
                    reset_value = `COLOR_BYTE_FIVE_RST;
                end
                6: begin
                    reset_value = `COLOR_BYTE_SIX_RST;
                end
                7: begin
                    reset_value = `COLOR_BYTE_SEVEN_RST;
                end
                default: begin
                    reset_value = `COLOR_BYTE_UPPER_RST;
                end
            endcase
        end
    endfunction

    // true while the fixed color sequence is selected
    function is_fixed;
        input mode;
        begin
            is_fixed = (mode == `MODE_FIXED_COLOR);
        end
    endfunction

    // next fixed color position, wrapping after the last table entry
    function [3:0] step_pos;
        input [3:0] pos;
        begin
            if (pos == LAST_POS) begin
                step_pos = FIRST_POS;
            end else begin
                step_pos = pos + 4'h1;
            end
        end
    endfunction

    // table entry that a request picks in either mode
    function [3:0] emit_slot;
        input mode;
        input [2:0] bar;
        input [3:0] pos;
        begin
            if (is_fixed(mode)) begin
                emit_slot = pos;
            end else begin
                emit_slot = {1'b0, bar};
            end
        end
    endfunction

    // ************************************************
    // write decode
    // ************************************************
    // one decode serves both the write and the read path
    wire [4:0] bus_slot = slot_of(reg_addr);
    wire [ENTRIES-1:0] wr_sel;

    genvar gi;
    generate
        for (gi = 0; gi < ENTRIES; gi = gi + 1) begin : g_wr_sel
            assign wr_sel[gi] = reg_wr && bus_slot[4] && (bus_slot[3:0] == gi);
        end
    endgenerate

    // ************************************************
    // color byte table
    // ************************************************
    reg [BYTE_W-1:0] color_reg [0:ENTRIES-1];
    integer k;

    // a write lands at its edge; a request in that same cycle still sees the old byte
    // software write path
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (k = 0; k < ENTRIES; k = k + 1) begin
                color_reg[k] <= reset_value(k);
            end
        end else begin
            for (k = 0; k < ENTRIES; k = k + 1) begin
                if (wr_sel[k]) begin
                    color_reg[k] <= reg_wdata;
                end
            end
        end
    end

    // ************************************************
    // register read
    // ************************************************
    // read data hold until the next read strobe
    // readback of every byte
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= {BYTE_W{1'b0}};
        end else if (reg_rd) begin
            if (bus_slot[4]) begin
                reg_rdata <= color_reg[bus_slot[3:0]];
            end else begin
                // unmapped offsets read as zero so software never sees a stale byte
                reg_rdata <= UNMAPPED_BYTE;
            end
        end
    end

    // ************************************************
    // byte selection
    // ************************************************
    // the sample is taken in the request cycle, so a write in an earlier
    // cycle is always seen and a same-cycle write shows from the next byte
    wire [3:0] sel_idx = emit_slot(gen_mode, gen_bar, gen_pos);
    reg [3:0] pos_next;

    always @* begin
        pos_next = gen_pos;
        if (is_fixed(gen_mode) && gen_req) begin
            pos_next = step_pos(gen_pos);
        end
        // restart wins over an advance in the same cycle
        if (gen_restart) begin
            pos_next = FIRST_POS;
        end
    end

    // ************************************************
    // byte output
    // ************************************************
    // gen_byte holds between requests so a slow consumer may sample late
    // registered table byte
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_byte <= {BYTE_W{1'b0}};
        end else if (gen_req) begin
            gen_byte <= color_reg[sel_idx];
        end
    end

    // one strobe per request, a cycle after it
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_valid <= 1'b0;
        end else begin
            gen_valid <= gen_req;
        end
    end

    // ************************************************
    // fixed color position
    // ************************************************
    // restart is honoured in either mode so a switch to fixed color starts clean
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_pos <= FIRST_POS;
        end else begin
            gen_pos <= pos_next;
        end
    end

endmodule

// ### tb/pattern_gen_color_bytes_monitor.sv
// port checker for the color byte table
`timescale 1ns/1ps
module pattern_gen_color_bytes_monitor #(parameter BYTE_W = 8) (
    input wire ref_clk, resetn, reg_wr, reg_rd, gen_mode, gen_restart, gen_req, gen_valid,
    input wire [7:0] reg_addr,
    input wire [BYTE_W-1:0] reg_wdata, reg_rdata, gen_byte,
    input wire [2:0] gen_bar,
    input wire [3:0] gen_pos);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // shadow table, so a wrong pick shows as a wrong byte
    logic [BYTE_W-1:0] tbl [16];
    wire hit = reg_addr[7:4] == 4'h1 && reg_addr[3:0] != 4'hf;
    wire [BYTE_W-1:0] rexp = hit ? tbl[reg_addr[3:0]] : 8'h00;
    wire [BYTE_W-1:0] gexp = tbl[gen_mode ? gen_pos : {1'b0, gen_bar}];
    always @(posedge ref_clk or negedge resetn)
        if (!resetn)
            tbl <= '{8'haa, 8'h33, 8'hf0, 8'h7f, 8'h55, 8'hcc, 8'h0f, 8'h80, 0, 0, 0, 0, 0, 0, 0, 0};
        else if (reg_wr && hit)
            tbl[reg_addr[3:0]] <= reg_wdata;
    sequence bar_req; gen_req && !gen_mode; endsequence
    sequence fix_req; gen_req && gen_mode; endsequence
    bar_high_a:
        assert property (bar_req ##0 gen_bar[2] |=> gen_byte == $past(gexp)) else $error("bar byte wrong");
    bar_low_a:
        assert property (bar_req ##0 !gen_bar[2] |=> gen_byte == $past(gexp)) else $error("low bar byte wrong");
    fix_low_a:
        assert property (fix_req ##0 gen_pos[3:2] == 2'b00 |=> gen_byte == $past(gexp)) else $error("low fixed byte wrong");
    fix_mid_a:
        assert property (fix_req ##0 gen_pos[3:2] == 2'b01 |=> gen_byte == $past(gexp)) else $error("fixed byte wrong");
    fix_upper_a:
        assert property (fix_req ##0 gen_pos[3:2] == 2'b10 |=> gen_byte == $past(gexp)) else $error("fixed byte wrong");
    fix_top_a:
        assert property (fix_req ##0 gen_pos[3:2] == 2'b11 |=> gen_byte == $past(gexp)) else $error("top byte wrong");
    pos_step_a:
        assert property (fix_req ##0 !gen_restart |=> gen_pos == ($past(gen_pos) == 4'he ? 4'h0 : $past(gen_pos) + 4'h1))
        else $error("position step wrong");
    pos_restart_a:
        assert property (gen_restart |=> gen_pos == 4'h0) else $error("restart position wrong");
    read_back_a:
        assert property (reg_rd |=> reg_rdata == $past(rexp)) else $error("read data wrong");
    valid_once_a:
        assert property (gen_req ##1 !gen_req |-> gen_valid ##1 !gen_valid) else $error("valid pulse wrong");
endmodule
bind pattern_gen_color_bytes pattern_gen_color_bytes_monitor #(.BYTE_W(BYTE_W)) u_mon (.ref_clk, .resetn,
    .reg_wr, .reg_rd, .gen_mode, .gen_restart, .gen_req, .gen_valid, .reg_addr, .reg_wdata, .reg_rdata,
    .gen_byte, .gen_bar, .gen_pos);

// ### tb/pattern_gen_color_bytes_test.sv
// self-checking bench for the color byte table
`timescale 1ns/1ps
module pattern_gen_color_bytes_test;
    logic ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, gen_mode = 0, gen_restart = 0, gen_req = 0, rd_d = 0;
    logic gen_valid;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, gen_byte, got, exp, i;
    logic [2:0] gen_bar = 0;
    logic [3:0] gen_pos, pos = 0;
    logic [7:0] m [16] = '{8'haa, 8'h33, 8'hf0, 8'h7f, 8'h55, 8'hcc, 8'h0f, 8'h80, 0, 0, 0, 0, 0, 0, 0, 0};
    logic [7:0] exp_q [$];
    int miscompares = 0, compares = 0;
    pattern_gen_color_bytes u_pattern_gen_color_bytes (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .gen_mode, .gen_restart, .gen_req, .gen_bar, .gen_byte, .gen_valid, .gen_pos);
    always #20 ref_clk = ~ref_clk;
    // one bus cycle; every strobe is set once, so back-to-back cycles never glitch
    task automatic cyc(bit w, bit r, bit q, bit s, bit md, logic [7:0] a, logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        gen_req <= q;
        gen_restart <= s;
        gen_mode <= md;
        reg_addr <= a;
        gen_bar <= a[2:0];
        reg_wdata <= d;
        if (r)
            exp_q.push_back((a[7:4] == 4'h1 && a[3:0] != 4'hf) ? m[a[3:0]] : 8'h00);
        if (q)
            exp_q.push_back(m[md ? pos : {1'b0, a[2:0]}]);
        if (q && md)
            pos = (pos == 4'he) ? 4'h0 : pos + 4'h1;
        if (s)
            pos = 4'h0;
        if (w && a[7:4] == 4'h1 && a[3:0] != 4'hf)
            m[a[3:0]] = d;
        @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) rd_d <= reg_rd;
    always @(negedge ref_clk) begin
        if (gen_valid === 1'b1 || rd_d) begin
            got = (gen_valid === 1'b1) ? gen_byte : reg_rdata;
            exp = exp_q.size() ? exp_q.pop_front() : 8'hxx;
            compares++;
            if (got !== exp) begin
                miscompares++;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    end
    task automatic print_verdict();
        if (exp_q.size() != 0)
            miscompares++;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (1000) @(posedge ref_clk);
        miscompares++;
        print_verdict();
    end
    initial begin
        void'($urandom(55));
        repeat (2) @(posedge ref_clk);
        resetn <= 1;
        repeat (3) @(posedge ref_clk);
        for (i = 15; i < 32; i++) cyc(0, 1, 0, 0, 0, i, 0);
        for (i = 0; i < 8; i++) cyc(0, 0, 1, 0, 0, i, 0);
        for (i = 15; i < 33; i++) cyc(1, 0, 0, 0, 0, i, 8'($urandom));
        for (i = 15; i < 33; i++) cyc(0, 1, 0, 0, 0, i, 0);
        cyc(0, 0, 0, 1, 1, 0, 0);
        for (i = 0; i < 32; i++) cyc(i[0], 0, 1, 0, 1, 8'h10 + pos, 8'($urandom));
        for (i = 0; i < 16; i++) cyc(1, 0, 1, 0, 0, 8'h10 + i[2:0], 8'($urandom));
        cyc(0, 0, 1, 1, 1, 0, 0);
        cyc(0, 0, 1, 0, 1, 0, 0);
        cyc(0, 0, 0, 0, 0, 0, 0);
        repeat (2) @(posedge ref_clk);
        print_verdict();
    end
endmodule
